// *** pfa_pkg.sv ***
// Package with the constants shared by the flow action qualifier files.
package pfa_pkg;
	// Sizes of the flow table, of the per-flow and common settings, and of the action FIFO.
	localparam int NUM_FLOWS = 8;
	localparam int NUM_CHANNELS = 2;
	localparam int FLOW_IDX_W = 3;
	localparam int STATUS_POS_W = 3;
	localparam int REWRITE_CNT_W = 4;
	localparam int REWRITE_POS_W = 8;
	localparam int CF_LOC_W = 8;
	localparam int OFFSET_W = 8;
	localparam int ADR_SEL_W = 2;
	localparam int GROUP_W = 2;
	localparam int FIFO_DEPTH = 4;

	// Address source encodings for the frame signature builder.
	localparam logic [1:0] ADR_FIRST_ETHERNET_COMPARATOR = 2'h0;
	localparam logic [1:0] ADR_ETH2 = 2'h1;
	localparam logic [1:0] ADR_IP1 = 2'h2;
	localparam logic [1:0] ADR_IP2 = 2'h3;

	// Checksum source encodings.
	localparam logic CKSUM_CMP1 = 1'h0;
	localparam logic CKSUM_CMP2 = 1'h1;

	// Bit positions of the next-protocol group bits.
	localparam int GROUP_A = 0;
	localparam int GROUP_B = 1;

	// Values after reset.
	localparam logic [NUM_FLOWS-1:0] RST_FLOW_EN = 8'h00;
	localparam logic RST_ENGINE_EN = 1'h0;

	// Layout of one action record in the FIFO.
	localparam int REC_W = 39;
	localparam int REC_GRPB = 0;
	localparam int REC_GRPA = 1;
	localparam int REC_ADR = 2;
	localparam int REC_CKSUM = 4;
	localparam int REC_CFLOC = 5;
	localparam int REC_RWPOS = 13;
	localparam int REC_RWCNT = 21;
	localparam int REC_UPD = 25;
	localparam int REC_SOFF = 26;
	localparam int REC_FLOW = 34;
	localparam int REC_TSALL = 37;
	localparam int REC_MATCH = 38;

	// Packet tracking states.
	typedef enum logic [1:0]
	{
		PKT_IDLE = 2'b01,
		PKT_BODY = 2'b10
	} pfa_pkt_state_t;
endpackage : pfa_pkg

// *** pfa_fifo.sv ***
// Shift-register FIFO whose head word sits in a flip-flop.
`timescale 1ns/10ps
module pfa_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
)(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic [CNT_W-1:0] wrIdx;
	logic push;
	logic pop;

	// Full is honest: a pop in the same cycle does not open the door.
	assign inReady = (count_ff != FULL_CNT);
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign wrIdx = pop ? count_ff - 1'b1 : count_ff;
	assign outData = mem_ff[0];

	// Occupancy count.
	always_comb
	begin
		nxt_count = count_ff;
		if (push && !pop)
			nxt_count = count_ff + 1'b1;
		else if (pop && !push)
			nxt_count = count_ff - 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_ff <= '0;
			outValid <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			outValid <= (nxt_count != '0);
		end
	end

	// Storage shifts toward the head on a pop; the new word lands behind the last one.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_ff[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				if (push && CNT_W'(i) == wrIdx)
					mem_ff[i] <= inData;
				else if (pop && i < DEPTH - 1)
					mem_ff[i] <= mem_ff[i+1];
			end
		end
	end
endmodule : pfa_fifo

// *** pfa_flow_qualify.sv ***
// Combinational qualification of per-flow hits and choice of the winning flow.
`timescale 1ns/10ps
module pfa_flow_qualify
	import pfa_pkg::*;
(
	// Active enables
	input wire logic engineEn,
	input wire logic ethCompEn,
	input wire logic strictMatch,
	input wire logic [NUM_FLOWS-1:0] flowEn,
	input wire logic [NUM_FLOWS-1:0] ethStageEn,
	// Per-flow qualifiers
	input wire logic [NUM_FLOWS*NUM_CHANNELS-1:0] flowChannelEnables,
	input wire logic [NUM_FLOWS*GROUP_W-1:0] protocolGroupQualifier,
	// Frame results
	input wire logic channel,
	input wire logic ethHeaderFound,
	input wire logic ethHitA,
	input wire logic ethHitB,
	input wire logic [NUM_FLOWS-1:0] flowHit,
	// Outcome
	output logic [NUM_FLOWS-1:0] qualified,
	output logic anyHit,
	output logic [FLOW_IDX_W-1:0] winner
);
	// Lowest numbered qualified flow wins, so software can rank flows by index.
	always_comb
	begin
		logic groupOk;
		logic stageOk;
		groupOk = 1'b0;
		stageOk = 1'b0;
		qualified = '0;
		anyHit = 1'b0;
		winner = '0;
		for (int f = 0; f < NUM_FLOWS; f++)
		begin
			groupOk = (protocolGroupQualifier[f*GROUP_W+GROUP_A] && ethHitA) ||
				(protocolGroupQualifier[f*GROUP_W+GROUP_B] && ethHitB);
			// A flow off in the Ethernet stage is dropped outright only under strict matching.
			stageOk = strictMatch ? ethStageEn[f] : 1'b1;
			if (ethCompEn)
				groupOk = groupOk && ethHeaderFound && (ethStageEn[f] || !strictMatch);
			else
				groupOk = 1'b1;
			qualified[f] = engineEn && flowEn[f] && flowHit[f] && stageOk && groupOk &&
				flowChannelEnables[f*NUM_CHANNELS+int'(channel)];
		end
		for (int f = NUM_FLOWS - 1; f >= 0; f--)
		begin
			if (qualified[f])
			begin
				anyHit = 1'b1;
				winner = FLOW_IDX_W'(f);
			end
		end
	end
endmodule : pfa_flow_qualify

// *** pfa_flow_action.sv ***
// Per-flow action selection for the frame rewriter, with packet-boundary enable handling.
`timescale 1ns/10ps
module pfa_flow_action
	import pfa_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Packet boundaries
	input wire logic pktSop,
	input wire logic pktEop,
	// Header analysis result
	input wire logic hdrDone,
	output logic hdrReady,
	input wire logic hdrChannel,
	input wire logic ethHeaderFound,
	input wire logic ethHitA,
	input wire logic ethHitB,
	input wire logic [NUM_FLOWS-1:0] flowHit,
	input wire logic [OFFSET_W-1:0] ptpHeaderOffset,
	// Enables, applied at packet boundaries
	input wire logic engineEn,
	input wire logic firstEthernetComparatorEn,
	input wire logic strictMatch,
	input wire logic [NUM_FLOWS-1:0] ethStageFlowEn,
	input wire logic [NUM_FLOWS-1:0] flowValidEn,
	// Per-flow settings
	input wire logic [NUM_FLOWS*NUM_CHANNELS-1:0] flowChannelEnables,
	input wire logic [NUM_FLOWS*GROUP_W-1:0] protocolGroupQualifier,
	input wire logic [NUM_FLOWS*STATUS_POS_W-1:0] statusBitBytePosition,
	input wire logic [NUM_FLOWS-1:0] statusBitUpdateEn,
	input wire logic [NUM_FLOWS*REWRITE_CNT_W-1:0] rewriteByteCount,
	input wire logic [NUM_FLOWS*REWRITE_POS_W-1:0] rewritePosition,
	input wire logic [NUM_FLOWS*CF_LOC_W-1:0] newCorrectionLocation,
	// Settings common to all flows
	input wire logic checksumSourceSelect,
	input wire logic [ADR_SEL_W-1:0] signatureAddressSource,
	// Action record toward the rewriter
	output logic actValid,
	input wire logic actReady,
	output logic actMatched,
	output logic actTimestampAll,
	output logic [FLOW_IDX_W-1:0] actFlow,
	output logic [OFFSET_W-1:0] actStatusBitOffset,
	output logic actStatusBitUpdate,
	output logic [REWRITE_CNT_W-1:0] actRewriteByteCount,
	output logic [REWRITE_POS_W-1:0] actRewritePosition,
	output logic [CF_LOC_W-1:0] actNewCorrectionLocation,
	output logic actChecksumSource,
	output logic [ADR_SEL_W-1:0] actAddressSource,
	output logic actGroupA,
	output logic actGroupB,
	// Status
	output logic engineActive,
	output logic [NUM_FLOWS-1:0] activeFlowEn
);
	pfa_pkt_state_t pktState_ff;
	pfa_pkt_state_t nxt_pktState;
	logic ethCompEn_ff;
	logic strict_ff;
	logic [NUM_FLOWS-1:0] ethStageEn_ff;
	logic boundary;
	logic accept;
	logic [NUM_FLOWS-1:0] qualified;
	logic anyHit;
	logic [FLOW_IDX_W-1:0] winner;
	logic [REC_W-1:0] nxt_rec;
	logic [REC_W-1:0] rec_ff;
	logic [REC_W-1:0] headRec;
	logic recValid_ff;
	logic nxt_recValid;
	logic fifoReady;
	logic recPush;
	logic [STATUS_POS_W-1:0] winStatusPos;

	// Packet tracking; a packet ends on the end-of-packet strobe.
	always_comb
	begin
		nxt_pktState = pktState_ff;
		case (pktState_ff)
			PKT_IDLE:
				if (pktSop && !pktEop)
					nxt_pktState = PKT_BODY;
			PKT_BODY:
				if (pktEop)
					nxt_pktState = PKT_IDLE;
			default:
				nxt_pktState = PKT_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pktState_ff <= PKT_IDLE;
		else
			pktState_ff <= nxt_pktState;
	end

	// Enables are sampled only in the gap, on the start-of-packet cycle or on the last cycle of a packet.
	assign boundary = (pktState_ff == PKT_IDLE) || pktEop;

	// The enable ports act as the pending copy; the active copy follows at a boundary.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			engineActive <= RST_ENGINE_EN;
			ethCompEn_ff <= 1'b0;
			strict_ff <= 1'b0;
			ethStageEn_ff <= RST_FLOW_EN;
			activeFlowEn <= RST_FLOW_EN;
		end
		else if (boundary)
		begin
			engineActive <= engineEn;
			ethCompEn_ff <= firstEthernetComparatorEn;
			strict_ff <= strictMatch;
			ethStageEn_ff <= ethStageFlowEn;
			activeFlowEn <= flowValidEn;
		end
	end

	// Qualification of the comparator hits against the active enables.
	pfa_flow_qualify u_qualify (
		.engineEn(engineActive),
		.ethCompEn(ethCompEn_ff),
		.strictMatch(strict_ff),
		.flowEn(activeFlowEn),
		.ethStageEn(ethStageEn_ff),
		.flowChannelEnables(flowChannelEnables),
		.protocolGroupQualifier(protocolGroupQualifier),
		.channel(hdrChannel),
		.ethHeaderFound(ethHeaderFound),
		.ethHitA(ethHitA),
		.ethHitB(ethHitB),
		.flowHit(flowHit),
		.qualified(qualified),
		.anyHit(anyHit),
		.winner(winner)
	);

	assign accept = hdrDone && hdrReady;
	assign winStatusPos = statusBitBytePosition[int'(winner)*STATUS_POS_W +: STATUS_POS_W];

	// Build the action record for the winning flow; a miss still yields a record.
	always_comb
	begin
		nxt_rec = '0;
		nxt_rec[REC_MATCH] = anyHit;
		nxt_rec[REC_TSALL] = engineActive && !ethCompEn_ff;
		nxt_rec[REC_FLOW +: FLOW_IDX_W] = winner;
		// The rewriter wants the bit's place from the Ethernet start, not the PTP start.
		nxt_rec[REC_SOFF +: OFFSET_W] = OFFSET_W'(ptpHeaderOffset + OFFSET_W'(winStatusPos));
		nxt_rec[REC_UPD] = anyHit && statusBitUpdateEn[winner];
		nxt_rec[REC_RWCNT +: REWRITE_CNT_W] = rewriteByteCount[int'(winner)*REWRITE_CNT_W +: REWRITE_CNT_W];
		nxt_rec[REC_RWPOS +: REWRITE_POS_W] = rewritePosition[int'(winner)*REWRITE_POS_W +: REWRITE_POS_W];
		nxt_rec[REC_CFLOC +: CF_LOC_W] = newCorrectionLocation[int'(winner)*CF_LOC_W +: CF_LOC_W];
		nxt_rec[REC_CKSUM] = checksumSourceSelect ? CKSUM_CMP2 : CKSUM_CMP1;
		nxt_rec[REC_ADR +: ADR_SEL_W] = signatureAddressSource;
		// Group bits are what the Ethernet stage hands forward to the next block.
		nxt_rec[REC_GRPA] = ethHeaderFound && ethHitA && (!anyHit ||
			protocolGroupQualifier[int'(winner)*GROUP_W+GROUP_A]);
		nxt_rec[REC_GRPB] = ethHeaderFound && ethHitB && (!anyHit ||
			protocolGroupQualifier[int'(winner)*GROUP_W+GROUP_B]);
	end

	// One-record holding stage; it stalls the analyzer while the FIFO is full.
	assign recPush = recValid_ff && fifoReady;
	assign nxt_recValid = (recValid_ff && !recPush) || accept;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			recValid_ff <= 1'b0;
			rec_ff <= '0;
			hdrReady <= 1'b0;
		end
		else
		begin
			recValid_ff <= nxt_recValid;
			hdrReady <= !nxt_recValid;
			if (accept)
				rec_ff <= nxt_rec;
		end
	end

	pfa_fifo #(
		.WIDTH(REC_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.inValid(recValid_ff),
		.inReady(fifoReady),
		.inData(rec_ff),
		.outValid(actValid),
		.outReady(actReady),
		.outData(headRec)
	);

	// Record fields toward the rewriter, straight from the FIFO head flops.
	assign actMatched = headRec[REC_MATCH];
	assign actTimestampAll = headRec[REC_TSALL];
	assign actFlow = headRec[REC_FLOW +: FLOW_IDX_W];
	assign actStatusBitOffset = headRec[REC_SOFF +: OFFSET_W];
	assign actStatusBitUpdate = headRec[REC_UPD];
	assign actRewriteByteCount = headRec[REC_RWCNT +: REWRITE_CNT_W];
	assign actRewritePosition = headRec[REC_RWPOS +: REWRITE_POS_W];
	assign actNewCorrectionLocation = headRec[REC_CFLOC +: CF_LOC_W];
	assign actChecksumSource = headRec[REC_CKSUM];
	assign actAddressSource = headRec[REC_ADR +: ADR_SEL_W];
	assign actGroupA = headRec[REC_GRPA];
	assign actGroupB = headRec[REC_GRPB];

	// Checks on the qualification, boundary and backpressure behaviour.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_midpacket_hold: assert property ((pktState_ff == PKT_BODY && !pktEop) |=>
		activeFlowEn == $past(activeFlowEn) && engineActive == $past(engineActive))
		else $error("Enable changed inside a packet.");
	a_gap_apply: assert property ((pktState_ff == PKT_IDLE) |=> activeFlowEn == $past(flowValidEn))
		else $error("Pending flow enable not applied in the gap.");
	a_channel_gate: assert property ((accept && anyHit) |->
		flowChannelEnables[int'(winner)*NUM_CHANNELS+int'(hdrChannel)])
		else $error("Flow matched on a masked channel.");
	a_flow_enable: assert property ((accept && anyHit) |-> activeFlowEn[winner] && engineActive)
		else $error("Disabled flow produced a match.");
	a_group_gate: assert property ((accept && anyHit && ethCompEn_ff) |->
		(protocolGroupQualifier[int'(winner)*GROUP_W+GROUP_A] && ethHitA) ||
		(protocolGroupQualifier[int'(winner)*GROUP_W+GROUP_B] && ethHitB))
		else $error("Match without a shared protocol group.");
	a_strict_stage: assert property ((accept && anyHit && strict_ff) |-> ethStageEn_ff[winner])
		else $error("Strict matching let a stage-disabled flow through.");
	a_no_header: assert property ((accept && ethCompEn_ff && !ethHeaderFound) |=>
		recValid_ff && !rec_ff[REC_MATCH])
		else $error("Match without an Ethernet header.");
	a_stamp_all: assert property ((accept && engineActive && !ethCompEn_ff) |=> rec_ff[REC_TSALL])
		else $error("Time stamp all not flagged with comparator off.");
	a_engine_off: assert property ((accept && !engineActive) |=> !rec_ff[REC_MATCH])
		else $error("Disabled engine produced a match.");
	a_backpressure: assert property ((recValid_ff && !fifoReady) |=> !hdrReady [*2] or recPush)
		else $error("Analyzer not stalled while the FIFO is full.");

	// The record contents below are checked one edge after the accept that loaded them.
	a_status_offset: assert property (accept |=>
		rec_ff[REC_SOFF +: OFFSET_W] == $past(OFFSET_W'(ptpHeaderOffset + OFFSET_W'(winStatusPos))))
		else $error("Status bit offset not taken from the Ethernet start.");
	// A miss must never ask the rewriter to touch the status bit.
	a_update_miss: assert property ((accept && !anyHit) |=> !rec_ff[REC_UPD])
		else $error("Status bit update requested on a miss.");
	// Common controls travel with every record, whatever the flow outcome.
	a_common_copy: assert property (accept |=> rec_ff[REC_CKSUM] == $past(checksumSourceSelect) &&
		rec_ff[REC_ADR +: ADR_SEL_W] == $past(signatureAddressSource))
		else $error("Common controls not carried into the record.");
	// Group bits handed forward need a found Ethernet header behind them.
	a_group_forward: assert property ((accept && !ethHeaderFound) |=>
		!rec_ff[REC_GRPA] && !rec_ff[REC_GRPB])
		else $error("Group bits forwarded without an Ethernet header.");
	// A disabled engine hands no rewriter work on, not even the stamp-all flag.
	a_engine_quiet: assert property ((accept && !engineActive) |=> !rec_ff[REC_UPD] && !rec_ff[REC_TSALL])
		else $error("Disabled engine requested rewriter work.");
	// The end-of-packet cycle is a boundary, so pending enables land on its edge.
	a_eop_apply: assert property (pktEop |=> activeFlowEn == $past(flowValidEn) &&
		engineActive == $past(engineEn))
		else $error("Pending enables not applied at end of packet.");
	// Head fields are levels for the rewriter, so they must hold through a stall.
	a_head_stable: assert property ((actValid && !actReady) |=> actValid && $stable(headRec))
		else $error("Head record changed while the rewriter stalled.");
	// The holding stage closes right after an accept, which spaces header results two cycles apart.
	a_accept_gap: assert property (accept |=> !hdrReady)
		else $error("Analyzer ready again right after an accept.");

	c_flow_match: cover property (accept && anyHit);
	c_stamp_all: cover property (accept && !ethCompEn_ff && engineActive);
	c_fifo_full: cover property (recValid_ff && !fifoReady);
	c_eop_apply: cover property (pktState_ff == PKT_BODY && pktEop && flowValidEn != activeFlowEn);
	c_miss_record: cover property (accept && !anyHit);
endmodule : pfa_flow_action

// *** pfa_rewriter_model.sv ***
// Behavioural rewriter that takes action records either at once or after a stall.
`timescale 1ns/10ps
module pfa_rewriter_model
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Action handshake
	input wire logic actValid,
	output logic actReady,
	// Test control
	input wire logic hold,
	output int pops
);
	// A stalled rewriter refuses the head, which is how the FIFO gets backed up.
	assign actReady = !hold;

	// Count every record taken so the bench can match it against headers sent.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pops <= 0;
		else if (actValid && actReady)
			pops <= pops + 1;
	end
endmodule : pfa_rewriter_model

// *** pfa_flow_action_tb.sv ***
// Self-checking bench for the per-flow action selector.
`timescale 1ns/10ps
module pfa_flow_action_tb
	import pfa_pkg::*;
;
	// Stimulus and observed signals.
	logic clock, rst_n, pktSop, pktEop, hdrDone, hdrChannel, ethHeaderFound, ethHitA, ethHitB, hold;
	logic engineEn, firstEthernetComparatorEn, strictMatch, checksumSourceSelect, hdrReady, actValid, actReady;
	logic actMatched, actTimestampAll, actStatusBitUpdate, actChecksumSource, actGroupA, actGroupB, engineActive;
	logic [7:0] flowHit, ptpHeaderOffset, ethStageFlowEn, flowValidEn, statusBitUpdateEn, activeFlowEn;
	logic [7:0] actStatusBitOffset, actRewritePosition, actNewCorrectionLocation;
	logic [15:0] flowChannelEnables, protocolGroupQualifier;
	logic [23:0] statusBitBytePosition;
	logic [31:0] rewriteByteCount;
	logic [63:0] rewritePosition, newCorrectionLocation;
	logic [1:0] signatureAddressSource, actAddressSource;
	logic [2:0] actFlow;
	logic [3:0] actRewriteByteCount;
	int errors, comparisons, cycles, pops, sent;

	pfa_flow_action dut (.clock, .rst_n, .pktSop, .pktEop, .hdrDone, .hdrReady, .hdrChannel, .ethHeaderFound,
		.ethHitA, .ethHitB, .flowHit, .ptpHeaderOffset, .engineEn, .firstEthernetComparatorEn, .strictMatch,
		.ethStageFlowEn, .flowValidEn, .flowChannelEnables, .protocolGroupQualifier, .statusBitBytePosition,
		.statusBitUpdateEn, .rewriteByteCount, .rewritePosition, .newCorrectionLocation, .checksumSourceSelect,
		.signatureAddressSource, .actValid, .actReady, .actMatched, .actTimestampAll, .actFlow,
		.actStatusBitOffset, .actStatusBitUpdate, .actRewriteByteCount, .actRewritePosition,
		.actNewCorrectionLocation, .actChecksumSource, .actAddressSource, .actGroupA, .actGroupB,
		.engineActive, .activeFlowEn);

	pfa_rewriter_model rewriter (.clock, .rst_n, .actValid, .actReady, .hold, .pops);

	// Free-running 200 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Cut a hung run short; the ceiling is far above what the scenarios need.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Inputs always change one nanosecond after the rising edge.
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	task automatic send(input logic [7:0] hit, input logic ch, input logic fnd, input logic a, input logic b);
		int n;
		n = 0;
		while (hdrReady !== 1'b1 && n < 50)
		begin
			step(1);
			n++;
		end
		{flowHit, hdrChannel, ethHeaderFound, ethHitA, ethHitB, hdrDone} = {hit, ch, fnd, a, b, 1'b1};
		step(1);
		hdrDone = 1'b0;
		sent++;
	endtask : send

	// Judge the head record, then let the rewriter take it at the next edge.
	task automatic exp_rec(input logic m, input logic [2:0] f, input logic ts, input logic ga, input logic gb);
		int n;
		n = 0;
		while (actValid !== 1'b1 && n < 50)
		begin
			step(1);
			n++;
		end
		chk(actMatched, m);
		chk(actFlow, f);
		chk(actStatusBitOffset, 8'(ptpHeaderOffset + 8'(f)));
		chk(actStatusBitUpdate, m & statusBitUpdateEn[f]);
		chk(actRewriteByteCount, 4'(f) + 4'h3);
		chk(actRewritePosition, 8'h10 + 8'(f));
		chk(actNewCorrectionLocation, 8'h20 + 8'(f));
		chk(actTimestampAll, ts);
		chk({actGroupA, actGroupB}, {ga, gb});
		chk(actChecksumSource, checksumSourceSelect);
		chk(actAddressSource, signatureAddressSource);
		step(1);
	endtask : exp_rec

	// Winner choice, group and channel qualification, missing header, status offset wrap.
	task automatic sc_match();
		send(8'h14, 1'b1, 1'b1, 1'b1, 1'b1);
		exp_rec(1'b1, 3'h2, 1'b0, 1'b1, 1'b0);
		send(8'h04, 1'b0, 1'b1, 1'b0, 1'b1);
		exp_rec(1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
		send(8'h02, 1'b0, 1'b1, 1'b1, 1'b1);
		exp_rec(1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
		send(8'h02, 1'b1, 1'b1, 1'b1, 1'b1);
		exp_rec(1'b1, 3'h1, 1'b0, 1'b1, 1'b1);
		send(8'h01, 1'b0, 1'b0, 1'b1, 1'b1);
		exp_rec(1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
		send(8'h20, 1'b1, 1'b1, 1'b1, 1'b0);
		exp_rec(1'b1, 3'h5, 1'b0, 1'b1, 1'b0);
	endtask : sc_match

	// Every address source and both checksum sources, changed only with the engine off.
	task automatic sc_common();
		for (int i = 0; i < 4; i++)
		begin
			engineEn = 1'b0;
			step(2);
			send(8'h80, 1'b0, 1'b1, 1'b1, 1'b1);
			exp_rec(1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
			signatureAddressSource = 2'(i);
			checksumSourceSelect = i[0];
			engineEn = 1'b1;
			step(2);
			send(8'h80, 1'b0, 1'b1, 1'b1, 1'b1);
			exp_rec(1'b1, 3'h7, 1'b0, 1'b1, 1'b1);
		end
	endtask : sc_common

	// Comparator off, strict matching and flow enable.
	task automatic sc_enables();
		firstEthernetComparatorEn = 1'b0;
		step(2);
		send(8'h08, 1'b0, 1'b0, 1'b0, 1'b0);
		exp_rec(1'b1, 3'h3, 1'b1, 1'b0, 1'b0);
		firstEthernetComparatorEn = 1'b1;
		ethStageFlowEn = 8'hf7;
		step(2);
		send(8'h08, 1'b0, 1'b1, 1'b0, 1'b1);
		exp_rec(1'b1, 3'h3, 1'b0, 1'b0, 1'b1);
		strictMatch = 1'b1;
		step(2);
		send(8'h08, 1'b0, 1'b1, 1'b0, 1'b1);
		exp_rec(1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
		flowValidEn = 8'hef;
		step(2);
		send(8'h10, 1'b0, 1'b1, 1'b1, 1'b1);
		exp_rec(1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
		{strictMatch, ethStageFlowEn, flowValidEn} = {1'b0, 8'hff, 8'hff};
		step(2);
	endtask : sc_enables

	// Enable changes inside a packet wait for its end.
	task automatic sc_boundary();
		pktSop = 1'b1;
		step(1);
		pktSop = 1'b0;
		flowValidEn = 8'hbf;
		engineEn = 1'b0;
		step(3);
		chk({engineActive, activeFlowEn}, 9'h1ff);
		send(8'h40, 1'b0, 1'b1, 1'b1, 1'b1);
		exp_rec(1'b1, 3'h6, 1'b0, 1'b1, 1'b1);
		pktEop = 1'b1;
		step(1);
		pktEop = 1'b0;
		chk({engineActive, activeFlowEn}, 9'h0bf);
		{engineEn, flowValidEn} = {1'b1, 8'hff};
		step(2);
	endtask : sc_boundary

	// Stalled rewriter: four records fill the FIFO, a fifth waits, then all drain in order.
	task automatic sc_fifo();
		hold = 1'b1;
		for (int i = 0; i < 5; i++)
			send(8'(1 << i), 1'b1, 1'b1, 1'b1, 1'b1);
		step(4);
		chk({hdrReady, actValid, actFlow}, 5'h08);
		hold = 1'b0;
		for (int i = 0; i < 5; i++)
			exp_rec(1'b1, 3'(i), 1'b0, protocolGroupQualifier[i*2], protocolGroupQualifier[i*2+1]);
		step(2);
		chk(actValid, 1'b0);
		chk(pops, sent);
	endtask : sc_fifo

	// Main sequence.
	initial
	begin
		{rst_n, pktSop, pktEop, hdrDone, hdrChannel, ethHeaderFound, ethHitA, ethHitB, hold} = 9'h0;
		{engineEn, firstEthernetComparatorEn, strictMatch, checksumSourceSelect} = 4'hc;
		{flowHit, ptpHeaderOffset, ethStageFlowEn, flowValidEn} = 32'h00feffff;
		{statusBitUpdateEn, signatureAddressSource} = {8'h55, 2'h0};
		{flowChannelEnables, protocolGroupQualifier} = {16'hfffb, 16'hff9f};
		// Distinct settings per flow so that a wrong flow selection shows.
		for (int f = 0; f < NUM_FLOWS; f++)
		begin
			statusBitBytePosition[f*3 +: 3] = 3'(f);
			rewriteByteCount[f*4 +: 4] = 4'(f) + 4'h3;
			rewritePosition[f*8 +: 8] = 8'h10 + 8'(f);
			newCorrectionLocation[f*8 +: 8] = 8'h20 + 8'(f);
		end
		errors = 0;
		comparisons = 0;
		cycles = 0;
		sent = 0;
		step(10);
		chk({hdrReady, actValid, engineActive}, 3'h0);
		rst_n = 1'b1;
		step(1);
		chk({hdrReady, engineActive, activeFlowEn}, 10'h3ff);
		sc_match();
		sc_common();
		sc_enables();
		sc_boundary();
		sc_fifo();
		complete_run();
	end
endmodule : pfa_flow_action_tb
